//--- core/cgr_pkg.sv
package cgr_pkg;

   // ----------------------------------------------------------------
   // register addresses (13-bit serial address space)
   // ----------------------------------------------------------------
   localparam logic [12:0] ADDR_SERIAL_SETUP   = 13'h000;
   localparam logic [12:0] ADDR_SPARE_ONE      = 13'h001;
   localparam logic [12:0] ADDR_HELD_BACK_TWO  = 13'h002;
   localparam logic [12:0] ADDR_DEVICE_ID      = 13'h003;
   localparam logic [12:0] ADDR_READBACK_SEL   = 13'h004;
   localparam logic [12:0] ADDR_CUST_VER_LOW   = 13'h005;
   localparam logic [12:0] ADDR_CUST_VER_HIGH  = 13'h006;
   localparam logic [12:0] ADDR_SPARE_FIRST    = 13'h007;
   localparam logic [12:0] ADDR_SPARE_LAST     = 13'h00f;
   localparam logic [12:0] ADDR_PFD_PUMP       = 13'h010;
   localparam logic [12:0] ADDR_REF_DIV_LOW    = 13'h011;
   localparam logic [12:0] ADDR_REF_DIV_HIGH   = 13'h012;
   localparam logic [12:0] ADDR_STEP           = 13'h001;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SETUP_SDO_HI    = 7;
   localparam int SETUP_LSBF_HI   = 6;
   localparam int SETUP_SRST_HI   = 5;
   localparam int SETUP_SRST_LO   = 2;
   localparam int SETUP_LSBF_LO   = 1;
   localparam int SETUP_SDO_LO    = 0;
   localparam int READBACK_BIT    = 0;
   localparam int REF_DIV_WIDTH   = 14;
   localparam int INSTR_RW_BIT    = 15;

   // ----------------------------------------------------------------
   // reset values and serial framing counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  SETUP_RST      = 8'h00;
   localparam logic        READBACK_RST   = 1'b0;
   localparam logic [7:0]  PFD_PUMP_RST   = 8'h7d;
   localparam logic [13:0] REF_DIV_RST    = 14'h0001;
   localparam logic [15:0] CUST_VER_RST   = 16'h0000;
   localparam logic [3:0]  INSTR_LAST_BIT = 4'hf;
   localparam logic [3:0]  BYTE_LAST_BIT  = 4'h7;

   // one bank of loop settings, held twice: buffered and active
   typedef struct packed {
      logic [7:0]  pfdPump;
      logic [13:0] refDiv;
      logic [15:0] custVer;
   } cgr_bank_t;

   localparam cgr_bank_t BANK_RST = '{pfdPump: PFD_PUMP_RST, refDiv: REF_DIV_RST,
                                      custVer: CUST_VER_RST};

   // serial engine states, gray along idle -> instruction -> data
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_INSTR = 2'b01,
      ST_DATA  = 2'b11
   } cgr_spi_state_t;

endpackage : cgr_pkg

//--- core/cgr_reg_front.sv
// What this block does
// RQ1: A write to an address outside the map changes no state at all.
// RQ2: Writes to unused addresses or unused bit positions have no effect.
// RQ3: In I2C mode the setup byte has soft reset at bits 5 and 2, self-clearing, all else unused.
// RQ4: Bit 0 of readback select makes reads return the active bank instead of the buffer.
// RQ5: The 16-bit customer version sits low byte first at 0x005 and 0x006, high byte reset zero.
// RQ6: The 14-bit reference divider splits over 0x011 and 0x012, bits 7:6 unused, low byte reset 1.
// RQ7: In SPI mode the setup byte mirrors output enable 7/0, bit order 6/1 and soft reset 5/2.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// pin filter: three flops, a change counts once stages two and three agree
// ----------------------------------------------------------------
module cgr_pin_filter #(
   parameter logic RST_LEVEL = 1'b0
) (
   // clock and reset
   input  logic clk_sys,
   input  logic rstn,
   // pin and filtered level
   input  logic pin,
   output logic level
);
   logic [2:0] stg;   // stage one is stg[0], read only by stage two

   // a one-cycle glitch never reaches level, at the cost of four cycles of delay
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stg   <= {3{RST_LEVEL}};
         level <= RST_LEVEL;
      end else begin
         stg   <= {stg[1:0], pin};
         level <= (stg[1] == stg[2]) ? stg[2] : level;
      end
   end
endmodule : cgr_pin_filter

// ----------------------------------------------------------------
// register front end with serial slave
// ----------------------------------------------------------------
module cgr_reg_front #(
   parameter logic [7:0] DEVICE_ID = 8'h5a   // arbitrary value
) (
   // clock and reset
   input  logic               clk_sys,
   input  logic               rstn,
   // serial port pins
   input  logic               sclk,
   input  logic               csbN,
   input  logic               sdioIn,
   output logic               sdioOut,
   output logic               sdioOen,
   output logic               sdoOut,
   output logic               sdoOen,
   // mode strap, high selects I2C layout of the setup byte
   input  logic               i2cMode,
   // bank transfer pulse and active settings
   input  logic               ioUpdate,
   output cgr_pkg::cgr_bank_t activeBank
);

   // ----------------------------------------------------------------
   // pin inputs
   // ----------------------------------------------------------------
   logic sclkF;
   logic csbF;
   logic sdioF;
   logic i2cF;
   cgr_pin_filter #(.RST_LEVEL(1'b0)) u_sclk (.clk_sys(clk_sys), .rstn(rstn), .pin(sclk),
                                              .level(sclkF));
   cgr_pin_filter #(.RST_LEVEL(1'b1)) u_csb  (.clk_sys(clk_sys), .rstn(rstn), .pin(csbN),
                                              .level(csbF));
   cgr_pin_filter #(.RST_LEVEL(1'b0)) u_sdio (.clk_sys(clk_sys), .rstn(rstn), .pin(sdioIn),
                                              .level(sdioF));
   cgr_pin_filter #(.RST_LEVEL(1'b0)) u_i2c  (.clk_sys(clk_sys), .rstn(rstn), .pin(i2cMode),
                                              .level(i2cF));
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cgr_pkg::cgr_spi_state_t state;
   logic                    sclkD;
   logic [3:0]              bitCnt;
   logic [15:0]             rxShift;
   logic [7:0]              txShift;
   logic                    txBit;
   logic                    driveOn;
   logic                    isRead;
   logic [12:0]             addr;
   logic                    sdoActive;
   logic                    lsbFirst;
   logic                    readbackActive;
   cgr_pkg::cgr_bank_t      bufBank;
   // edges only count inside a frame
   wire sclkRise = sclkF & ~sclkD & ~csbF;
   wire sclkFall = ~sclkF & sclkD & ~csbF;
   wire [12:0] nextAddr = lsbFirst ? addr + cgr_pkg::ADDR_STEP : addr - cgr_pkg::ADDR_STEP;
   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   // a write lands only on the last bit of each data byte
   wire       wrEn       = (state == cgr_pkg::ST_DATA) & sclkRise & ~isRead &
                           (bitCnt == cgr_pkg::BYTE_LAST_BIT);
   wire [7:0] wrData     = {rxShift[6:0], sdioF};
   wire       hitSetup   = wrEn & (addr == cgr_pkg::ADDR_SERIAL_SETUP);
   wire       hitRb      = wrEn & (addr == cgr_pkg::ADDR_READBACK_SEL);
   wire       hitCvLow   = wrEn & (addr == cgr_pkg::ADDR_CUST_VER_LOW);
   wire       hitCvHigh  = wrEn & (addr == cgr_pkg::ADDR_CUST_VER_HIGH);
   wire       hitPump    = wrEn & (addr == cgr_pkg::ADDR_PFD_PUMP);
   wire       hitRdLow   = wrEn & (addr == cgr_pkg::ADDR_REF_DIV_LOW);
   wire       hitRdHigh  = wrEn & (addr == cgr_pkg::ADDR_REF_DIV_HIGH);
   // RQ3 RQ7 soft reset bits
   wire       softReset  = hitSetup & (wrData[cgr_pkg::SETUP_SRST_HI] |
                                       wrData[cgr_pkg::SETUP_SRST_LO]);
   // RQ7 mirrored control bits
   wire       setupWr    = hitSetup & ~softReset & ~i2cF;
   wire       next_sdo   = wrData[cgr_pkg::SETUP_SDO_HI] | wrData[cgr_pkg::SETUP_SDO_LO];
   wire       next_lsbf  = wrData[cgr_pkg::SETUP_LSBF_HI] | wrData[cgr_pkg::SETUP_LSBF_LO];
   // ----------------------------------------------------------------
   // read selection
   // ----------------------------------------------------------------
   // RQ4 bank chosen for reads
   cgr_pkg::cgr_bank_t rdBank;
   assign rdBank = readbackActive ? activeBank : bufBank;
   // RQ3 RQ7 setup readback, soft reset always reads zero
   wire [7:0] setupRead = i2cF ? 8'h00 : {sdoActive, lsbFirst, 4'h0, lsbFirst, sdoActive};
   // RQ2 unused and reserved bytes read zero
   wire [7:0] rdByte =
      (addr == cgr_pkg::ADDR_SERIAL_SETUP)  ? setupRead :
      (addr == cgr_pkg::ADDR_DEVICE_ID)     ? DEVICE_ID :
      (addr == cgr_pkg::ADDR_READBACK_SEL)  ? {7'h00, readbackActive} :
      (addr == cgr_pkg::ADDR_CUST_VER_LOW)  ? rdBank.custVer[7:0] :
      (addr == cgr_pkg::ADDR_CUST_VER_HIGH) ? rdBank.custVer[15:8] :
      (addr == cgr_pkg::ADDR_PFD_PUMP)      ? rdBank.pfdPump :
      (addr == cgr_pkg::ADDR_REF_DIV_LOW)   ? rdBank.refDiv[7:0] :
      (addr == cgr_pkg::ADDR_REF_DIV_HIGH)  ? {2'h0, rdBank.refDiv[13:8]} : 8'h00;

   // ----------------------------------------------------------------
   // serial engine
   // ----------------------------------------------------------------
   // shift in on rising sclk, frame aborts whenever chip select rises
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state   <= cgr_pkg::ST_IDLE;
         sclkD   <= 1'b0;
         bitCnt  <= 4'h0;
         rxShift <= 16'h0000;
         isRead  <= 1'b0;
         addr    <= 13'h0000;
      end else begin
         sclkD <= sclkF;
         if (csbF) begin
            state  <= cgr_pkg::ST_IDLE;
            bitCnt <= 4'h0;
         end else begin
            case (state)
               cgr_pkg::ST_IDLE: begin
                  state <= cgr_pkg::ST_INSTR;
               end
               cgr_pkg::ST_INSTR: begin
                  if (sclkRise) begin
                     rxShift <= {rxShift[14:0], sdioF};
                     bitCnt  <= bitCnt + 4'h1;
                     if (bitCnt == cgr_pkg::INSTR_LAST_BIT) begin
                        isRead <= rxShift[cgr_pkg::INSTR_RW_BIT - 1];
                        addr   <= {rxShift[11:0], sdioF};
                        state  <= cgr_pkg::ST_DATA;
                     end
                  end
               end
               default: begin
                  if (sclkRise) begin
                     rxShift <= {rxShift[14:0], sdioF};
                     if (bitCnt == cgr_pkg::BYTE_LAST_BIT) begin
                        bitCnt <= 4'h0;
                        addr   <= nextAddr;
                     end else begin
                        bitCnt <= bitCnt + 4'h1;
                     end
                  end
               end
            endcase
         end
      end
   end
   // shift out on falling sclk, a new byte is fetched at each byte start
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txShift <= 8'h00;
         txBit   <= 1'b0;
         driveOn <= 1'b0;
         sdoOen  <= 1'b1;
         sdioOen <= 1'b1;
      end else begin
         if (csbF) begin
            driveOn <= 1'b0;
         end else if (sclkFall & isRead & (state == cgr_pkg::ST_DATA)) begin
            driveOn <= 1'b1;
            txBit   <= (bitCnt == 4'h0) ? rdByte[7] : txShift[7];
            txShift <= (bitCnt == 4'h0) ? {rdByte[6:0], 1'b0} : {txShift[6:0], 1'b0};
         end
         // enables low while driving; three-wire reads use sdio
         sdoOen  <= ~(driveOn & ~csbF & sdoActive);
         sdioOen <= ~(driveOn & ~csbF & ~sdoActive);
      end
   end
   assign sdoOut  = txBit;
   assign sdioOut = txBit;
   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   // RQ1 only decoded hits and the ioUpdate transfer update state
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sdoActive      <= cgr_pkg::SETUP_RST[cgr_pkg::SETUP_SDO_HI];
         lsbFirst       <= cgr_pkg::SETUP_RST[cgr_pkg::SETUP_LSBF_HI];
         readbackActive <= cgr_pkg::READBACK_RST;
         bufBank        <= cgr_pkg::BANK_RST;
         activeBank     <= cgr_pkg::BANK_RST;
      end else if (softReset) begin
         // RQ3 soft reset restores defaults
         sdoActive      <= cgr_pkg::SETUP_RST[cgr_pkg::SETUP_SDO_HI];
         lsbFirst       <= cgr_pkg::SETUP_RST[cgr_pkg::SETUP_LSBF_HI];
         readbackActive <= cgr_pkg::READBACK_RST;
         bufBank        <= cgr_pkg::BANK_RST;
         activeBank     <= cgr_pkg::BANK_RST;
      end else begin
         if (setupWr) begin
            sdoActive <= next_sdo;
            lsbFirst  <= next_lsbf;
         end
         // RQ4 single select bit
         if (hitRb) readbackActive <= wrData[cgr_pkg::READBACK_BIT];
         // RQ5 version bytes
         if (hitCvLow) bufBank.custVer[7:0] <= wrData;
         if (hitCvHigh) bufBank.custVer[15:8] <= wrData;
         if (hitPump) bufBank.pfdPump <= wrData;
         // RQ6 divider bytes, top two bits dropped
         if (hitRdLow) bufBank.refDiv[7:0] <= wrData;
         if (hitRdHigh) bufBank.refDiv[13:8] <= wrData[5:0];
         // transfer takes the buffer as it stood before this edge
         if (ioUpdate) activeBank <= bufBank;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   wire mapped = (addr <= cgr_pkg::ADDR_READBACK_SEL) | (addr == cgr_pkg::ADDR_CUST_VER_LOW) |
                 (addr == cgr_pkg::ADDR_CUST_VER_HIGH) | (addr >= cgr_pkg::ADDR_PFD_PUMP &
                 addr <= cgr_pkg::ADDR_REF_DIV_HIGH);

   property p_unmapped;
      @(posedge clk_sys) disable iff (!rstn)
      (wrEn & ~mapped & ~ioUpdate) |=> $stable(bufBank) && $stable(activeBank) &&
                                       $stable(readbackActive) && $stable(sdoActive);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state"); // RQ1
   property p_rb_unused;
      @(posedge clk_sys) disable iff (!rstn)
      (hitRb & ~softReset) |=> readbackActive == $past(wrData[0]) && $stable(bufBank);
   endproperty
   a_rb_unused: assert property (p_rb_unused) else $error("readback write wrong"); // RQ2
   property p_soft_reset;
      @(posedge clk_sys) disable iff (!rstn)
      softReset |=> (bufBank == cgr_pkg::BANK_RST) && (activeBank == cgr_pkg::BANK_RST) &&
                    !readbackActive && (setupRead == 8'h00);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete"); // RQ3
   property p_i2c_setup;
      @(posedge clk_sys) disable iff (!rstn)
      (hitSetup & i2cF & ~softReset) |=> $stable(sdoActive) && $stable(lsbFirst);
   endproperty
   a_i2c_setup: assert property (p_i2c_setup) else $error("i2c unused bit took effect"); // RQ3
   property p_readback_bank;
      @(posedge clk_sys) disable iff (!rstn)
      (addr == cgr_pkg::ADDR_PFD_PUMP) |->
         rdByte == (readbackActive ? activeBank.pfdPump : bufBank.pfdPump);
   endproperty
   a_readback_bank: assert property (p_readback_bank) else $error("wrong bank read"); // RQ4
   property p_cust_ver;
      @(posedge clk_sys) disable iff (!rstn)
      (hitCvHigh & ~ioUpdate) |=> bufBank.custVer[15:8] == $past(wrData) &&
                                  $stable(bufBank.custVer[7:0]);
   endproperty
   a_cust_ver: assert property (p_cust_ver) else $error("version high byte wrong"); // RQ5
   property p_ref_div;
      @(posedge clk_sys) disable iff (!rstn)
      hitRdHigh |=> bufBank.refDiv[13:8] == $past(wrData[5:0]) &&
                    $stable(bufBank.refDiv[7:0]);
   endproperty
   a_ref_div: assert property (p_ref_div) else $error("divider high byte wrong"); // RQ6
   property p_mirror;
      @(posedge clk_sys) disable iff (!rstn)
      setupWr |=> sdoActive == $past(next_sdo) && lsbFirst == $past(next_lsbf) &&
                  (setupRead[7] == setupRead[0]) && (setupRead[6] == setupRead[1]);
   endproperty
   a_mirror: assert property (p_mirror) else $error("setup mirror wrong"); // RQ7
endmodule : cgr_reg_front

//--- bench/cgr_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host side of the serial port: master, MSB first, clock idles low
// ----------------------------------------------------------------
module cgr_host_model (
   // clock
   input  wire logic clk_sys,
   // pins driven by the host
   output logic      sclk,
   output logic      csbN,
   output logic      sdioHost,
   output logic      hostEn,
   // resolved data lines seen by the host
   input  wire logic sdioWire,
   input  wire logic sdoWire
);
   localparam int HALF = 8;  // clk per sclk half, above the filter's need of 5

   logic [7:0] dat [4];
   logic       useSdo;

   // pins quiet until the first frame
   initial begin
      sclk     = 1'b0;
      csbN     = 1'b1;
      sdioHost = 1'b0;
      hostEn   = 1'b0;
      useSdo   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // data set while sclk is low, taken by the device on the rise
   task automatic send_bit(input logic b);
      sclk     = 1'b0;
      sdioHost = b;
      tick(HALF);
      sclk = 1'b1;
      tick(HALF);
   endtask : send_bit

   // device shifts on the fall; sample just before the next rise
   task automatic get_bit(output logic b);
      sclk = 1'b0;
      tick(HALF);
      b    = useSdo ? sdoWire : sdioWire;
      sclk = 1'b1;
      tick(HALF);
   endtask : get_bit

   // instruction then n bytes; the device steps the address itself
   task automatic frame(input logic rd, input logic [12:0] addr, input int n);
      logic [15:0] instr;
      logic        b;
      instr  = {rd, 2'b11, addr};
      hostEn = 1'b1;
      csbN   = 1'b0;
      tick(HALF);
      for (int i = 15; i >= 0; i--) begin
         send_bit(instr[i]);
      end
      // line handed over to the device for reads
      hostEn = !rd;
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            if (rd) begin
               get_bit(b);
               dat[k][i] = b;
            end else begin
               send_bit(dat[k][i]);
            end
         end
      end
      sclk     = 1'b0;
      sdioHost = ~sdioHost;  // a released line must not keep the last bit
      tick(HALF);
      csbN   = 1'b1;
      hostEn = 1'b0;
      tick(2 * HALF);
   endtask : frame
endmodule : cgr_host_model

//--- bench/testbench.sv
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("unexpected %s: expected %h, seen %h", what, exp, got); \
      end \
   end

module testbench;
   localparam logic [7:0] ID_VAL = 8'h3c;  // arbitrary identifier value
   localparam cgr_pkg::cgr_bank_t BANK_DEF = {8'h7d, 14'h0001, 16'h0000};

   logic               clk_sys;
   logic               rstn;
   logic               i2cMode;
   logic               ioUpdate;
   logic               flt = 1'b0;
   logic               sclk, csbN, sdioHost, hostEn;
   logic               sdioOut, sdioOen, sdoOut, sdoOen;
   logic               sdioWire, sdoWire;
   cgr_pkg::cgr_bank_t activeBank;
   cgr_pkg::cgr_bank_t expBank;
   logic [12:0]        badAddr [6] = '{13'h001, 13'h002, 13'h003, 13'h007, 13'h00f, 13'h1fff};
   int                 error_cnt = 0;
   int                 tests_run = 0;

   // undriven lines toggle every cycle so a stale value never passes
   assign sdioWire = !sdioOen ? sdioOut : (hostEn ? sdioHost : flt);
   assign sdoWire  = !sdoOen ? sdoOut : flt;
   always @(posedge clk_sys) flt <= ~flt;

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   cgr_reg_front #(.DEVICE_ID(ID_VAL)) cgr_reg_front_inst (
      .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .csbN(csbN), .sdioIn(sdioWire),
      .sdioOut(sdioOut), .sdioOen(sdioOen), .sdoOut(sdoOut), .sdoOen(sdoOen),
      .i2cMode(i2cMode), .ioUpdate(ioUpdate), .activeBank(activeBank));

   cgr_host_model cgr_host_model_inst (
      .clk_sys(clk_sys), .sclk(sclk), .csbN(csbN), .sdioHost(sdioHost),
      .hostEn(hostEn), .sdioWire(sdioWire), .sdoWire(sdoWire));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      cgr_host_model_inst.dat[0] = d;
      cgr_host_model_inst.frame(1'b0, a, 1);
   endtask : wr

   task automatic chk_rd(input logic [12:0] a, input logic [7:0] exp, input string what);
      cgr_host_model_inst.frame(1'b1, a, 1);
      `CHECK(what, exp, cgr_host_model_inst.dat[0])
   endtask : chk_rd

   task automatic wr2(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1);
      cgr_host_model_inst.dat[0] = d0;
      cgr_host_model_inst.dat[1] = d1;
      cgr_host_model_inst.frame(1'b0, a, 2);
   endtask : wr2

   // one-cycle transfer pulse, then let the copy land
   task automatic update();
      ioUpdate = 1'b1;
      tick(1);
      ioUpdate = 1'b0;
      tick(2);
   endtask : update

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   // watchdog: the sequence needs about 16500 cycles
   initial begin
      repeat (80000) @(posedge clk_sys);
      error_cnt++;
      $display("unexpected run length: expected end of tests, seen none");
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      rstn     = 1'b0;
      i2cMode  = 1'b0;
      ioUpdate = 1'b0;
      tick(20);
      rstn = 1'b1;
      tick(8);
      `CHECK("active after reset", BANK_DEF, activeBank)
      chk_rd(13'h010, 8'h7d, "pump default");
      chk_rd(13'h011, 8'h01, "divider low default");
      chk_rd(13'h006, 8'h00, "version high default");
      chk_rd(13'h000, 8'h00, "setup default");
      chk_rd(13'h003, ID_VAL, "identifier");
      $display("test defaults done");
      // buffered write, transfer and readback bank choice
      wr(13'h010, 8'hab);
      chk_rd(13'h010, 8'hab, "pump buffered");
      `CHECK("pump before update", 8'h7d, activeBank.pfdPump)
      update();
      `CHECK("pump after update", 8'hab, activeBank.pfdPump)
      wr(13'h004, 8'hff);
      wr(13'h010, 8'h55);
      chk_rd(13'h004, 8'h01, "readback unused bits");
      chk_rd(13'h010, 8'hab, "pump from active bank");
      wr(13'h004, 8'h00);
      chk_rd(13'h010, 8'h55, "pump from buffer bank");
      $display("test readback done");
      // streamed pair walks down from the high byte
      wr2(13'h006, 8'h12, 8'h34);
      wr(13'h012, 8'hff);
      wr(13'h011, 8'hc3);
      update();
      `CHECK("version", 16'h1234, activeBank.custVer)
      `CHECK("divider", 14'h3fc3, activeBank.refDiv)
      chk_rd(13'h012, 8'h3f, "divider high unused bits");
      $display("test pairs done");
      // stray writes to unmapped, reserved and read-only places
      foreach (badAddr[i]) begin
         wr(badAddr[i], 8'he7);
      end
      update();
      expBank = '{pfdPump: 8'h55, refDiv: 14'h3fc3, custVer: 16'h1234};
      `CHECK("bank after stray writes", expBank, activeBank)
      chk_rd(13'h003, ID_VAL, "identifier read only");
      chk_rd(13'h007, 8'h00, "spare byte");
      $display("test stray writes done");
      // mirrored setup bits in serial mode
      wr(13'h000, 8'h81);
      cgr_host_model_inst.useSdo = 1'b1;
      chk_rd(13'h000, 8'h81, "setup four wire");
      wr(13'h000, 8'h42);
      cgr_host_model_inst.useSdo = 1'b0;
      wr2(13'h005, 8'h77, 8'h66);
      chk_rd(13'h006, 8'h66, "ascending stream");
      chk_rd(13'h000, 8'h42, "setup mirror");
      wr(13'h000, 8'h20);
      chk_rd(13'h000, 8'h00, "setup after soft reset");
      chk_rd(13'h005, 8'h00, "buffer after soft reset");
      `CHECK("active after soft reset", BANK_DEF, activeBank)
      $display("test serial setup done");
      // two-wire layout: only the soft reset copies count
      i2cMode = 1'b1;
      tick(8);
      wr(13'h000, 8'hdb);
      chk_rd(13'h000, 8'h00, "two-wire setup unused bits");
      wr(13'h010, 8'h99);
      update();
      `CHECK("pump before two-wire reset", 8'h99, activeBank.pfdPump)
      wr(13'h000, 8'h04);
      `CHECK("active after two-wire reset", BANK_DEF, activeBank)
      chk_rd(13'h000, 8'h00, "soft reset self clear");
      $display("test two-wire setup done");
      report_and_stop();
   end
endmodule : testbench
